// file: tlp_port.sv
`timescale 1ns/100ps
// Function
// R1 - Eight transmit line clocks, lines 7 down to 0, each timing its own line's serial data.
// R2 - Each transmit clock pin is driven or received according to the drive enable and its source bit.
// R3 - With drive enable high the clocks come from the internal source after reset until software picks another.
// R4 - In unstructured high speed mode only transmit line 0 runs; lines 1 to 7 stay inactive.
// R5 - In unstructured high speed mode only line 0 receive signaling is taken; the rest are ignored.
// R6 - In the structured modes each transmit frame sync input marks that line's frame boundary.
// R7 - Each multiframe sync edge realigns that line's multiframe counter to the edge position.
// R8 - Multiframe sync may be rare; between marks the multiframe count free-runs. A frame sync edge resets the position without advancing the count.
// R9 - In structured multiframe mode signaling bits go out per line, low during reset.
// R10 - Line data goes out serially per line, low during reset.
// R11 - In structured multiframe mode receive signaling bits are captured per line.
// R12 - Eight receive serial inputs are accepted, one per line.
// R13 - Eight receive clocks, one per line; only line 0 is used in unstructured high speed mode.
// R14 - In the structured modes each receive frame sync input aligns that line's receive bits.
// R15 - One bit moves per line clock period, launched and sampled on that line's clock edges.
// R16 - Every line-side input is brought into the system clock domain before use.
module tlp_port
   import tlp_pkg::*;
#(
   parameter int FRAME_BITS = 193,
   parameter int MF_FRAMES = 24
) (
   input wire logic clk_in, // System clock
   input wire logic arst_n_in, // Async reset, active low
   input wire logic [4:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   input wire logic tx_clock_drive_enable_in, // Clock drive strap
   input wire logic [7:0] tx_line_clock_in, // Tx clock pin input
   output logic [7:0] tx_line_clock_out, // Tx clock pin output
   output logic [7:0] tx_line_clock_oe_out, // Tx clock pin drive
   input wire logic [7:0] tx_line_frame_sync_in, // Tx frame sync
   input wire logic [7:0] tx_line_multiframe_sync_in, // Tx multiframe sync
   output logic [7:0] tx_line_signaling_out, // Tx signaling
   output logic [7:0] tx_line_serial_data_out, // Tx serial data
   input wire logic [7:0] rx_line_clock_in, // Rx clocks
   input wire logic [7:0] rx_line_frame_sync_in, // Rx frame sync
   input wire logic [7:0] rx_line_serial_data_in, // Rx serial data
   input wire logic [7:0] rx_line_signaling_in // Rx signaling
);
   localparam int POS_W = $clog2(FRAME_BITS);
   localparam int MF_W = $clog2(MF_FRAMES);
   localparam logic [POS_W-1:0] POS_LAST = POS_W'(FRAME_BITS - 1);
   localparam logic [MF_W-1:0] MF_LAST = MF_W'(MF_FRAMES - 1);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   tlp_pins_type pins_in;
   tlp_pins_type meta_reg;
   tlp_pins_type sync_reg;
   logic [7:0] tx_clk_prev_reg;
   logic [7:0] rx_clk_prev_reg;

   assign pins_in = '{drive_en: tx_clock_drive_enable_in, tx_clk: tx_line_clock_in,
                      tx_fs: tx_line_frame_sync_in, tx_mfs: tx_line_multiframe_sync_in,
                      rx_clk: rx_line_clock_in, rx_fs: rx_line_frame_sync_in,
                      rx_ser: rx_line_serial_data_in, rx_sig: rx_line_signaling_in};

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_reg <= '0;
         sync_reg <= '0;
         tx_clk_prev_reg <= '0;
         rx_clk_prev_reg <= '0;
      end else begin
         meta_reg <= pins_in; // R16
         sync_reg <= meta_reg; // R16
         tx_clk_prev_reg <= sync_reg.tx_clk;
         rx_clk_prev_reg <= sync_reg.rx_clk;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Internal line clock from a divider
   // Half period rounds down, so the internal clock runs a little fast
   logic [3:0] div_cnt_reg;
   logic int_clk_reg;
   wire int_tick = (div_cnt_reg == INT_HALF_CYC - 4'h1);
   wire int_rise = int_tick & ~int_clk_reg;
   wire int_fall = int_tick & int_clk_reg;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div_cnt_reg <= '0;
         int_clk_reg <= 1'b0;
      end else begin
         div_cnt_reg <= int_tick ? 4'h0 : div_cnt_reg + 4'h1;
         if (int_tick) begin
            int_clk_reg <= ~int_clk_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers and bus slave
   tlp_mode_type mode_reg;
   logic [7:0] clk_src_ext_reg;
   logic [7:0] tx_sig_reg;
   logic [31:0] rdata_reg;
   logic wait_reg;
   logic [1:0] buf_cnt_reg;
   logic [7:0] rx_valid;
   logic [7:0] rx_clear;
   logic [7:0] rx_sig_cap;
   logic [7:0] rx_byte [8];
   logic [MF_W-1:0] mf0_count;
   logic [2:0] rx_sel;

   wire uhs = (mode_reg == MODE_UNSTRUCTURED_HIGH_SPEED);
   wire structured = ~uhs;
   wire buf_full = (buf_cnt_reg == 2'd2);
   wire sel_tx_data = (avs_address == OFS_TX_DATA);
   wire bus_req = (avs_read | avs_write) & wait_reg;
   // Full buffer stalls the master rather than dropping the word
   wire accept = bus_req & ~(avs_write & sel_tx_data & buf_full);
   wire wr_en = accept & avs_write;
   wire rd_en = accept & avs_read;
   wire push = wr_en & sel_tx_data;
   wire rx_pop = rd_en & (avs_address == OFS_RX_DATA) & (|rx_valid);

   always_comb begin
      rx_sel = 3'd0;
      for (int i = 7; i >= 0; i--) begin
         if (rx_valid[i]) begin
            rx_sel = 3'(i);
         end
      end
   end

   wire [31:0] rd_rx_data = {20'h0_0000, |rx_valid, rx_sel, rx_byte[rx_sel]};
   // Status word: strap, buffer fill, then line 0 multiframe count in its own field
   localparam int ST_PAD_W = ST_MF0_LSB - ST_BUF_CNT_LSB - 2;
   wire [4:0] mf0_field = 5'(mf0_count);
   wire [31:0] rd_status = {19'h0_0000, mf0_field, ST_PAD_W'(0), buf_cnt_reg,
                            sync_reg.drive_en};
   wire [31:0] rd_mux =
      (avs_address == OFS_CTRL) ? {30'h0000_0000, mode_reg} :
      (avs_address == OFS_CLK_SRC) ? {24'h00_0000, clk_src_ext_reg} :
      (avs_address == OFS_TX_SIG) ? {24'h00_0000, tx_sig_reg} :
      (avs_address == OFS_RX_DATA) ? rd_rx_data :
      (avs_address == OFS_RX_SIG) ? {24'h00_0000, rx_sig_cap} :
      (avs_address == OFS_STATUS) ? rd_status : RDATA_RESET;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wait_reg <= 1'b1;
         rdata_reg <= RDATA_RESET;
         mode_reg <= MODE_STRUCTURED_MULTIFRAME;
         clk_src_ext_reg <= CLK_SRC_RESET; // R3
         tx_sig_reg <= TX_SIG_RESET;
      end else begin
         wait_reg <= ~accept;
         if (rd_en) begin
            rdata_reg <= rd_mux;
         end
         if (wr_en && avs_address == OFS_CTRL) begin
            mode_reg <= (avs_writedata[1:0] == 2'b11) ? MODE_UNSTRUCTURED_HIGH_SPEED :
                        tlp_mode_type'(avs_writedata[1:0]);
         end
         if (wr_en && avs_address == OFS_CLK_SRC) begin
            clk_src_ext_reg <= avs_writedata[7:0]; // R3
         end
         if (wr_en && avs_address == OFS_TX_SIG) begin
            tx_sig_reg <= avs_writedata[7:0];
         end
      end
   end

   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rdata_reg;
   assign rx_clear = rx_pop ? 8'(1 << rx_sel) : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Two-entry transmit buffer
   tlp_txword_type buf_mem [2];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [7:0] load_line;
   tlp_txword_type head;

   assign head = buf_mem[rd_ptr_reg];
   wire buf_valid = (buf_cnt_reg != 2'd0);
   // Words for idle lines in high speed mode would block line 0 forever
   wire drop = buf_valid & uhs & (head.line != 3'd0); // R4
   wire pop = (|load_line) | drop;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         buf_cnt_reg <= 2'd0;
      end else begin
         if (push) begin
            buf_mem[wr_ptr_reg] <= tlp_txword_type'(avs_writedata[10:0]);
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         buf_cnt_reg <= buf_cnt_reg + 2'(push) - 2'(pop);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-line transmit and receive
   for (genvar g = 0; g < 8; g++) begin : g_line
      wire line_on = structured | (g == 0);
      wire use_ext = clk_src_ext_reg[g] | ~sync_reg.drive_en; // R2
      wire ext_rise = sync_reg.tx_clk[g] & ~tx_clk_prev_reg[g];
      wire ext_fall = ~sync_reg.tx_clk[g] & tx_clk_prev_reg[g];
      wire tx_rise = use_ext ? ext_rise : int_rise; // R1
      wire tx_fall = use_ext ? ext_fall : int_fall; // R15
      wire rx_rise = sync_reg.rx_clk[g] & ~rx_clk_prev_reg[g]; // R13
      logic [7:0] sh_reg;
      logic [2:0] cnt_reg;
      logic full_reg;
      logic [POS_W-1:0] pos_reg;
      logic [MF_W-1:0] mf_reg;
      logic fs_prev_reg;
      logic mfs_prev_reg;
      logic ser_reg;
      logic sig_reg;
      logic clk_reg;
      logic oe_reg;
      logic [7:0] rsh_reg;
      logic [2:0] rcnt_reg;
      logic rfs_prev_reg;
      logic [7:0] rbyte_reg;
      logic rvalid_reg;
      logic rsig_reg;

      assign load_line[g] = tx_fall & line_on & ~full_reg & buf_valid &
                            (head.line == 3'(g));
      wire fs_edge = sync_reg.tx_fs[g] & ~fs_prev_reg & structured;
      wire mfs_edge = sync_reg.tx_mfs[g] & ~mfs_prev_reg;
      wire rfs_edge = sync_reg.rx_fs[g] & ~rfs_prev_reg & structured;
      wire rdone = rx_rise & line_on & (rfs_edge | rcnt_reg == 3'd7);

      always_ff @(posedge clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            sh_reg <= '0;
            cnt_reg <= '0;
            full_reg <= 1'b0;
            ser_reg <= 1'b0; // R10
            sig_reg <= 1'b0; // R9
            clk_reg <= 1'b0;
            oe_reg <= 1'b0;
         end else begin
            clk_reg <= line_on & int_clk_reg; // R4
            oe_reg <= line_on & ~use_ext; // R2
            if (!line_on) begin
               ser_reg <= 1'b0; // R4
               sig_reg <= 1'b0;
               full_reg <= 1'b0;
            end else if (tx_fall) begin
               sig_reg <= (mode_reg == MODE_STRUCTURED_MULTIFRAME) & tx_sig_reg[g]; // R9
               if (load_line[g]) begin
                  ser_reg <= head.data[7]; // R10
                  sh_reg <= {head.data[6:0], 1'b0};
                  cnt_reg <= 3'd1;
                  full_reg <= 1'b1;
               end else if (full_reg) begin
                  ser_reg <= sh_reg[7]; // R15
                  sh_reg <= {sh_reg[6:0], 1'b0};
                  cnt_reg <= cnt_reg + 3'd1;
                  full_reg <= (cnt_reg != 3'd7);
               end else begin
                  ser_reg <= IDLE_BIT;
               end
            end
         end
      end

      // Frame and multiframe position on the framer's sampling edge
      always_ff @(posedge clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            pos_reg <= '0;
            mf_reg <= '0;
            fs_prev_reg <= 1'b0;
            mfs_prev_reg <= 1'b0;
         end else if (tx_rise) begin
            fs_prev_reg <= sync_reg.tx_fs[g];
            mfs_prev_reg <= sync_reg.tx_mfs[g];
            if (mfs_edge) begin
               pos_reg <= '0; // R7
               mf_reg <= '0; // R7
            end else if (fs_edge) begin
               pos_reg <= '0; // R6
            end else if (pos_reg == POS_LAST) begin
               pos_reg <= '0;
               mf_reg <= (mf_reg == MF_LAST) ? '0 : mf_reg + MF_W'(1); // R8
            end else begin
               pos_reg <= pos_reg + POS_W'(1);
            end
         end
      end

      always_ff @(posedge clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            rsh_reg <= '0;
            rcnt_reg <= '0;
            rfs_prev_reg <= 1'b0;
            rbyte_reg <= '0;
            rvalid_reg <= 1'b0;
            rsig_reg <= 1'b0;
         end else begin
            if (rx_rise && line_on) begin
               rfs_prev_reg <= sync_reg.rx_fs[g];
               rsh_reg <= {rsh_reg[6:0], sync_reg.rx_ser[g]}; // R12
               rcnt_reg <= rfs_edge ? 3'd1 : rcnt_reg + 3'd1; // R14
               if (mode_reg == MODE_STRUCTURED_MULTIFRAME) begin
                  rsig_reg <= sync_reg.rx_sig[g]; // R11
               end else if (uhs) begin
                  rsig_reg <= sync_reg.rx_sig[g] & (g == 0); // R5
               end
            end
            if (rdone && !rfs_edge) begin
               rbyte_reg <= {rsh_reg[6:0], sync_reg.rx_ser[g]};
            end
            // A byte landing with the read that clears it stays valid
            rvalid_reg <= (rdone & ~rfs_edge) | (rvalid_reg & ~rx_clear[g]);
         end
      end

      assign tx_line_serial_data_out[g] = ser_reg;
      assign tx_line_signaling_out[g] = sig_reg;
      assign tx_line_clock_out[g] = clk_reg;
      assign tx_line_clock_oe_out[g] = oe_reg;
      assign rx_valid[g] = rvalid_reg;
      assign rx_byte[g] = rbyte_reg;
      assign rx_sig_cap[g] = rsig_reg & line_on; // R5
   end

   assign mf0_count = g_line[0].mf_reg;
endmodule : tlp_port

// file: tlp_pkg.sv
package tlp_pkg;
   // Register byte addresses
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_CLK_SRC = 5'h04;
   localparam logic [4:0] OFS_TX_DATA = 5'h08;
   localparam logic [4:0] OFS_TX_SIG = 5'h0C;
   localparam logic [4:0] OFS_RX_DATA = 5'h10;
   localparam logic [4:0] OFS_RX_SIG = 5'h14;
   localparam logic [4:0] OFS_STATUS = 5'h18;
   // Field positions
   localparam int RXD_VALID_BIT = 11;
   localparam int ST_DRIVE_EN_BIT = 0;
   localparam int ST_BUF_CNT_LSB = 1;
   localparam int ST_MF0_LSB = 8;
   // Reset values
   localparam logic [7:0] CLK_SRC_RESET = 8'h00;
   localparam logic [7:0] TX_SIG_RESET = 8'h00;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
   // Internal line clock: half period in system cycles, rounded down
   localparam int SYS_CLK_HZ = 40_000_000;
   localparam int LINE_RATE_HZ = 1_544_000;
   localparam logic [3:0] INT_HALF_CYC = 4'(SYS_CLK_HZ / (2 * LINE_RATE_HZ));
   localparam logic IDLE_BIT = 1'b1;

   typedef enum logic [1:0] {
      MODE_STRUCTURED_MULTIFRAME = 2'b00,
      MODE_STRUCTURED_FRAME = 2'b01,
      MODE_UNSTRUCTURED_HIGH_SPEED = 2'b10
   } tlp_mode_type;

   typedef struct packed {
      logic drive_en;
      logic [7:0] tx_clk;
      logic [7:0] tx_fs;
      logic [7:0] tx_mfs;
      logic [7:0] rx_clk;
      logic [7:0] rx_fs;
      logic [7:0] rx_ser;
      logic [7:0] rx_sig;
   } tlp_pins_type;

   typedef struct packed {
      logic [2:0] line;
      logic [7:0] data;
   } tlp_txword_type;
endpackage : tlp_pkg

// file: tlp_port_monitor.sv
`timescale 1ns/100ps
module tlp_port_monitor
   import tlp_pkg::*;
(
   input wire logic clk_in, // System clock
   input wire logic arst_n_in, // Reset
   input wire logic [4:0] avs_address, // Address
   input wire logic avs_read, // Read
   input wire logic avs_write, // Write
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [31:0] avs_readdata, // Read data
   input wire logic avs_waitrequest, // Stall
   input wire logic tx_clock_drive_enable_in, // Strap
   input wire logic [7:0] tx_line_clock_out, // Clock out
   input wire logic [7:0] tx_line_clock_oe_out, // Clock drive
   input wire logic [7:0] tx_line_signaling_out, // Signaling
   input wire logic [7:0] tx_line_serial_data_out // Serial
);
   logic [1:0] mode_reg;
   logic [7:0] src_reg;
   logic [5:0] age_reg;
   logic [4:0] gap_reg, oe_age_reg;
   logic ser0_reg;
   wire acc_wr = avs_write && !avs_waitrequest;
   wire hs = mode_reg[1];
   wire ser_chg = ser0_reg != tx_line_serial_data_out[0];
   ////////////////////////////////////////
   // Shadow of the mode and source registers, ages gate settling
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mode_reg <= 2'h0;
         src_reg <= 8'h00;
         age_reg <= 6'h00;
         gap_reg <= 5'h1F;
         oe_age_reg <= 5'h00;
         ser0_reg <= 1'b0;
      end else begin
         if (acc_wr && avs_address == OFS_CTRL) mode_reg <= avs_writedata[1:0];
         if (acc_wr && avs_address == OFS_CLK_SRC) src_reg <= avs_writedata[7:0];
         age_reg <= acc_wr ? 6'h00 : (age_reg == 6'h3F ? age_reg : age_reg + 6'h01);
         gap_reg <= ser_chg ? 5'h00 : (gap_reg == 5'h1F ? gap_reg : gap_reg + 5'h01);
         oe_age_reg <= !tx_line_clock_oe_out[0] ? 5'h00 :
            (oe_age_reg == 5'h1F ? oe_age_reg : oe_age_reg + 5'h01);
         ser0_reg <= tx_line_serial_data_out[0];
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_one_cycle: assert property ((avs_read || (avs_write && avs_address != OFS_TX_DATA))
      && avs_waitrequest |=> !avs_waitrequest) else $error("access not answered in one cycle");
   a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address == 5'h1C
      |=> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
   a_reset_quiet: assert property ($rose(arst_n_in) |-> tx_line_serial_data_out == 8'h00
      && tx_line_signaling_out == 8'h00 && avs_waitrequest) else $error("outputs not quiet");
   a_oe_off: assert property ((!tx_clock_drive_enable_in)[*4]
      |-> tx_line_clock_oe_out == 8'h00) else $error("clock driven with strap low");
   a_oe_on: assert property (tx_clock_drive_enable_in[*4] ##0 (age_reg >= 6'h07)
      |-> tx_line_clock_oe_out == ((hs ? 8'h01 : 8'hFF) & ~src_reg))
      else $error("clock drive does not match source");
   a_hs_quiet: assert property (hs && age_reg == 6'h3F |-> {tx_line_serial_data_out[7:1],
      tx_line_signaling_out[7:1], tx_line_clock_out[7:1], tx_line_clock_oe_out[7:1]} == 28'h0)
      else $error("inactive line moves in high speed mode");
   a_bit_spacing: assert property (ser_chg && oe_age_reg == 5'h1F |-> gap_reg >= 5'd20)
      else $error("serial bit shorter than a line clock period");
   c_tx_stall: cover property ((avs_write && avs_waitrequest)[*3]);
   c_hs_mode: cover property (hs && age_reg == 6'h3F);
   c_rx_read: cover property (avs_read && !avs_waitrequest && avs_address == OFS_RX_DATA);
endmodule : tlp_port_monitor

bind tlp_port tlp_port_monitor i_mon (.clk_in(clk_in), .arst_n_in(arst_n_in),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .tx_clock_drive_enable_in(tx_clock_drive_enable_in),
   .tx_line_clock_out(tx_line_clock_out), .tx_line_clock_oe_out(tx_line_clock_oe_out),
   .tx_line_signaling_out(tx_line_signaling_out),
   .tx_line_serial_data_out(tx_line_serial_data_out));

// file: tlp_framer_model.sv
`timescale 1ns/100ps
module tlp_framer_model (
   input wire logic [7:0] pattern_in, // Byte repeated on rx lines
   output logic [7:0] rx_line_clock_out, // Rx clocks
   output logic [7:0] rx_line_frame_sync_out, // Rx frame sync
   output logic [7:0] rx_line_serial_data_out, // Rx serial data
   output logic [7:0] tx_line_clock_out // Tx clock for pin-clocked lines
);
   logic rclk = 1'b0;
   logic tclk = 1'b0;
   logic [2:0] bit_idx = 3'h0;
   // Line clocks run free, unrelated in phase to the system clock
   always #100 rclk = ~rclk;
   initial begin
      #37;
      forever #100 tclk = ~tclk;
   end
   assign rx_line_clock_out = {8{rclk}};
   assign tx_line_clock_out = {8{tclk}};
   // Odd lines carry the inverse so that lines can be told apart
   always @(negedge rclk) begin
      for (int k = 0; k < 8; k++) rx_line_serial_data_out[k] <= pattern_in[7 - bit_idx] ^ k[0];
      rx_line_frame_sync_out <= {8{bit_idx == 3'h0}};
      bit_idx <= bit_idx + 3'h1;
   end
endmodule : tlp_framer_model

// file: tlp_port_bench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tlp_port_bench;
   import tlp_pkg::*;
   localparam int FB = 8;
   localparam int MF = 4;
   logic clk_in = 1'b0, arst_n_in = 1'b0, avs_read = 1'b0, avs_write = 1'b0, strap = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] tx_fs = 8'h00, tx_mfs = 8'h00, rx_sig = 8'h00, pat = 8'h00;
   logic [7:0] tclk_o, tclk_oe, tsig, tser, rclk, rfs, rser, ext_clk;
   wire [7:0] tclk_pin = (tclk_oe & tclk_o) | (~tclk_oe & ext_clk);
   logic [31:0] q_exp[$], q_msk[$];
   logic bit_q[$];
   logic started = 1'b0, clk0_q = 1'b0;
   int fails = 0, n_tests = 0, cyc = 0, samp = 0;
   always #12.5 clk_in = ~clk_in;
   tlp_port #(.FRAME_BITS(FB), .MF_FRAMES(MF)) i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .tx_clock_drive_enable_in(strap),
      .tx_line_clock_in(tclk_pin), .tx_line_clock_out(tclk_o), .tx_line_clock_oe_out(tclk_oe),
      .tx_line_frame_sync_in(tx_fs), .tx_line_multiframe_sync_in(tx_mfs),
      .tx_line_signaling_out(tsig), .tx_line_serial_data_out(tser), .rx_line_clock_in(rclk),
      .rx_line_frame_sync_in(rfs), .rx_line_serial_data_in(rser), .rx_line_signaling_in(rx_sig));
   tlp_framer_model i_framer (.pattern_in(pat), .rx_line_clock_out(rclk),
      .rx_line_frame_sync_out(rfs), .rx_line_serial_data_out(rser), .tx_line_clock_out(ext_clk));
   ////////////////////////////////////////
   task automatic give_verdict();
      $display("Comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_in);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      cyc = 0;
      do begin
         @(posedge clk_in);
         cyc++;
      end while (avs_waitrequest !== 1'b0 && cyc < 2000);
      if (cyc >= 2000) fails++;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
      q_exp.push_back(e & m);
      q_msk.push_back(m);
      bus(1'b0, a, 32'h0000_0000);
   endtask : rd
   // First byte of a burst starts with 0 to tell it from idle ones
   task automatic burst(input int k, output int t);
      tlp_txword_type w;
      t = 0;
      for (int i = 0; i < k; i++) begin
         w.line = 3'h0;
         w.data = 8'($urandom);
         if (i == 0) w.data[7] = 1'b0;
         for (int j = 7; j >= 0; j--) bit_q.push_back(w.data[j]);
         wr(OFS_TX_DATA, 32'(w));
         t += cyc;
      end
   endtask : burst
   ////////////////////////////////////////
   always @(posedge clk_in) begin : rd_watch
      logic [31:0] e;
      logic [31:0] m;
      if (avs_read && avs_waitrequest === 1'b0 && q_exp.size() > 0) begin
         e = q_exp.pop_front();
         m = q_msk.pop_front();
         `CHK("readdata", e, avs_readdata & m)
      end
   end
   // Sample line 0 well inside the bit, after its clock fall
   always @(posedge clk_in) begin : bit_watch
      logic b;
      clk0_q <= tclk_o[0];
      if (clk0_q && !tclk_o[0]) samp <= 8;
      else if (samp != 0) samp <= samp - 1;
      if (samp == 1 && bit_q.size() > 0 && (started || tser[0] === 1'b0)) begin
         started = 1'b1;
         b = bit_q.pop_front();
         `CHK("serial0", b, tser[0])
      end
      if (bit_q.size() == 0) started = 1'b0;
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      fails++;
      give_verdict();
   end
   initial begin : main
      logic [31:0] r;
      tlp_txword_type w;
      int t;
      r = $urandom(32'h8f8a_5f08);
      pat = r[7:0];
      repeat (12) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      `CHK("oe", 8'hFF, tclk_oe)
      rd(OFS_CLK_SRC, 32'(CLK_SRC_RESET), 32'h0000_00FF);
      wr(OFS_CLK_SRC, 32'h0000_00F0);
      repeat (6) @(posedge clk_in);
      `CHK("oe", 8'h0F, tclk_oe)
      strap <= 1'b0;
      repeat (6) @(posedge clk_in);
      `CHK("oe", 8'h00, tclk_oe)
      strap <= 1'b1;
      rd(5'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
      r = $urandom;
      wr(OFS_TX_SIG, r);
      rx_sig <= r[15:8];
      repeat (80) @(posedge clk_in);
      `CHK("signaling", r[7:0], tsig)
      @(posedge rfs[0]);
      @(posedge rfs[0]);
      repeat (40) @(posedge clk_in);
      rd(OFS_RX_DATA, {20'h0_0000, 1'b1, 3'h0, pat}, 32'h0000_0FFF);
      rd(OFS_RX_DATA, {20'h0_0000, 1'b1, 3'h1, ~pat}, 32'h0000_0FFF);
      rd(OFS_RX_SIG, 32'(r[15:8]), 32'h0000_00FF);
      tx_mfs[0] <= 1'b1;
      repeat (30) @(posedge clk_in);
      rd(OFS_STATUS, 32'h0000_0000, 32'h0000_1F00);
      tx_mfs[0] <= 1'b0;
      repeat (FB * 24 + 88) @(posedge clk_in);
      rd(OFS_STATUS, 32'(1 % MF) << ST_MF0_LSB, 32'h0000_1F00);
      repeat (FB * 72) @(posedge clk_in);
      rd(OFS_STATUS, 32'(4 % MF) << ST_MF0_LSB, 32'h0000_1F00);
      // Frame sync every four line clocks keeps any frame from completing
      repeat (4) begin
         tx_fs[0] <= 1'b1;
         repeat (48) @(posedge clk_in);
         tx_fs[0] <= 1'b0;
         repeat (48) @(posedge clk_in);
      end
      rd(OFS_STATUS, 32'h0000_0000, 32'h0000_1F00);
      burst(4, t);
      `CHK("stall", 1'b1, t > 150)
      repeat (900) @(posedge clk_in);
      `CHK("drained", 0, bit_q.size())
      for (int m = 0; m < 4; m++) begin
         wr(OFS_CTRL, 32'(m));
         rd(OFS_CTRL, (m > 2) ? 32'(MODE_UNSTRUCTURED_HIGH_SPEED) : 32'(m), 32'h0000_0003);
      end
      w.line = 3'h5;
      w.data = r[7:0];
      wr(OFS_TX_DATA, 32'(w));
      burst(1, t);
      rx_sig <= ~r[15:8];
      repeat (40) @(posedge clk_in);
      rd(OFS_RX_SIG, {31'h0000_0000, ~r[8]}, 32'h0000_00FF);
      repeat (300) @(posedge clk_in);
      `CHK("high speed", 14'h0000, {tser[7:1], tsig[7:1]})
      `CHK("drained", 0, bit_q.size())
      give_verdict();
   end
endmodule : tlp_port_bench
